// ### design/sllc_regs.vh
/*
 * Constants for the serial link lock control block: frame layout,
 * training word, lock thresholds and timing counts.
 * Assumes a 10 MHz system clock and includes by bare name.
 */
`ifndef SLLC_REGS_VH
`define SLLC_REGS_VH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define SLLC_WORD_W 10
`define SLLC_FRAME_BITS 12
`define SLLC_LAST_BIT 4'hb
`define SLLC_TRAIN_WORD 10'h001
`define SLLC_IDLE_WORD 10'h000

// ----------------------------------------------------------------------
// Training and lock thresholds
// ----------------------------------------------------------------------
`define SLLC_TRAIN_SYMBOLS 11'h400
`define SLLC_LOSS_COUNT 3'h4
`define SLLC_GOOD_COUNT 3'h4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SLLC_CLK_NS 100
`define SLLC_BIT_NS 800
`define SLLC_BIT_CYC (`SLLC_BIT_NS / `SLLC_CLK_NS)
// Divider reload, one less than the clocks in a bit time
`define SLLC_BIT_RELOAD 4'h7
`define SLLC_LOCK_PWRUP_NS 3500
`define SLLC_LOCK_PWRUP_CYC (`SLLC_LOCK_PWRUP_NS / `SLLC_CLK_NS)
`define SLLC_LOCK_PAT_NS 1500
`define SLLC_LOCK_PAT_CYC (`SLLC_LOCK_PAT_NS / `SLLC_CLK_NS)
// Watchdog limits sized to its 6-bit timer: 35 and 15 clocks
`define SLLC_LOCK_PWRUP_LIM 6'h23
`define SLLC_LOCK_PAT_LIM 6'h0f

`endif

// ### design/sllc_fifo.v
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none

module sllc_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire clock,
   input wire rst,
   input wire [WIDTH-1:0] inData,
   input wire inValid,
   output reg inReady_ff,
   output wire [WIDTH-1:0] outData,
   output wire outValid,
   input wire outReady
);

   localparam [AW:0] FULL_C = DEPTH;

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr_ff;
   reg [AW-1:0] rdPtr_ff;
   reg [AW:0] count_ff;
   reg [AW:0] nxt_count;
   wire push;
   wire pop;

   // ---------------------------------------------------------------
   // Handshakes
   // ---------------------------------------------------------------
   assign push = inValid & inReady_ff;
   assign outValid = (count_ff != {(AW+1){1'b0}});
   assign pop = outValid & outReady;
   assign outData = mem[rdPtr_ff];

   // Occupancy after this cycle
   always @* begin
      nxt_count = count_ff;
      if (push & ~pop)
         nxt_count = count_ff + 1'b1;
      else if (pop & ~push)
         nxt_count = count_ff - 1'b1;
   end

   // Registered ready keeps the top's outputs flop-driven
   always @(posedge clock) begin
      if (rst) begin
         wrPtr_ff <= {AW{1'b0}};
         rdPtr_ff <= {AW{1'b0}};
         count_ff <= {(AW+1){1'b0}};
         inReady_ff <= 1'b0;
      end else begin
         if (push)
            wrPtr_ff <= wrPtr_ff + 1'b1;
         if (pop)
            rdPtr_ff <= rdPtr_ff + 1'b1;
         count_ff <= nxt_count;
         inReady_ff <= (nxt_count < FULL_C);
      end
   end

   // Storage, no reset needed
   always @(posedge clock) begin
      if (push)
         mem[wrPtr_ff] <= inData;
   end

endmodule // sllc_fifo

`default_nettype wire

// ### design/sllc_link_lock.v
/*
 * Serializer and deserializer link control: frame sender with training
 * patterns and sleep, frame receiver with lock search and loss detect.
 * Assumes a 10 MHz clock; pins and the reference clock are asynchronous.
 */
// Notes on behaviour
// - Send each word with two clock bits
// - Watch clock bits, raise lock flag on loss
// - Lock flag stays high until locked
// - Word outputs released only once locked
// - Either pattern request sends training patterns
// - Lock also found on random data
// - Words valid while lock flag low
// - Sender disabled loses lock, needs resync
// - Lock bound after power-up or wake; code only flags the overrun on lockLate_ff
// - Lock bound when patterns start arriving; code times from loss and only flags the overrun on lockLate_ff
// - Four bad clock bits declare loss
// - Request sends at least 1024 training symbols
// - Sleep stops sender, output undriven
`timescale 1ns/10ps
`default_nettype none
`include "sllc_regs.vh"

module sllc_link_lock (
   input wire clock,
   input wire rst,
   input wire [9:0] txWord,
   input wire txValid,
   output wire txReady,
   input wire patternRequestA,
   input wire patternRequestB,
   input wire sleepRequestN,
   output reg serialOutPos_ff,
   output reg serialOutNeg_ff,
   output reg serialOeN_ff,
   input wire referenceClockIn,
   input wire serialInPos,
   input wire serialInNeg,
   output reg lockN_ff,
   output reg [9:0] parallelWordOut_ff,
   output reg parallelOeN_ff,
   output reg wordStrobe_ff,
   output reg lockLate_ff
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   reg [4:0] pattern_request_a_ff;
   reg [4:0] pattern_request_b_ff;
   reg refPrev_ff;
   reg sleepPrev_ff;
   wire reqSync = pattern_request_b_ff[0] | pattern_request_b_ff[1];
   wire awake = pattern_request_b_ff[2];
   wire refRise = pattern_request_b_ff[3] & ~refPrev_ff;
   wire rxBit = pattern_request_b_ff[4];

   // Only stage two is ever read by logic
   always @(posedge clock) begin
      if (rst) begin
         pattern_request_a_ff <= 5'h00;
         pattern_request_b_ff <= 5'h00;
         refPrev_ff <= 1'b0;
         sleepPrev_ff <= 1'b0;
      end else begin
         pattern_request_a_ff <= {serialInPos & ~serialInNeg, referenceClockIn,
                      sleepRequestN, patternRequestB, patternRequestA};
         pattern_request_b_ff <= pattern_request_a_ff;
         refPrev_ff <= pattern_request_b_ff[3];
         sleepPrev_ff <= awake;
      end
   end

   // ---------------------------------------------------------------
   // Transmit buffer
   // ---------------------------------------------------------------
   wire [9:0] fifoWord;
   wire fifoValid;
   reg fifoPop_ff;

   sllc_fifo #(.WIDTH(10), .DEPTH(4), .AW(2)) uFifo (
      .clock(clock),
      .rst(rst),
      .inData(txWord),
      .inValid(txValid),
      .inReady_ff(txReady),
      .outData(fifoWord),
      .outValid(fifoValid),
      .outReady(fifoPop_ff)
   );

   // ---------------------------------------------------------------
   // Serializer
   // ---------------------------------------------------------------
   reg [3:0] bitDiv_ff;
   reg [3:0] txBit_ff;
   reg [9:0] txData_ff;
   reg [10:0] trainCnt_ff;
   wire bitTick = (bitDiv_ff == 4'h0);
   wire frameStart = bitTick & (txBit_ff == `SLLC_LAST_BIT);
   wire training = reqSync | (trainCnt_ff != 11'h000);

   // Bit timing divider, one tick per bit time
   always @(posedge clock) begin
      if (rst | ~awake)
         bitDiv_ff <= 4'h0;
      else if (bitTick)
         bitDiv_ff <= `SLLC_BIT_RELOAD;
      else
         bitDiv_ff <= bitDiv_ff - 4'h1;
   end

   // Frame sequencer; the pop is one cycle and an empty FIFO sends idle, never stalls us
   always @(posedge clock) begin
      if (rst | ~awake) begin
         txBit_ff <= `SLLC_LAST_BIT;
         txData_ff <= `SLLC_IDLE_WORD;
         trainCnt_ff <= 11'h000;
         fifoPop_ff <= 1'b0;
         serialOutPos_ff <= 1'b0;
         serialOutNeg_ff <= 1'b0;
         serialOeN_ff <= 1'b1;
      end else begin
         fifoPop_ff <= 1'b0;
         // Symbols counted per frame; request held keeps reloading
         if (reqSync)
            trainCnt_ff <= `SLLC_TRAIN_SYMBOLS;
         else if (frameStart & (trainCnt_ff != 11'h000))
            trainCnt_ff <= trainCnt_ff - 11'h001;
         if (frameStart) begin
            txBit_ff <= 4'h0;
            if (training) begin
               txData_ff <= `SLLC_TRAIN_WORD;
            end else if (fifoValid) begin
               txData_ff <= fifoWord;
               fifoPop_ff <= 1'b1;
            end else begin
               txData_ff <= `SLLC_IDLE_WORD;
            end
         end else if (bitTick) begin
            txBit_ff <= txBit_ff + 4'h1;
         end
         // Start bit high, data LSB first, stop bit low
         if (bitTick) begin
            serialOeN_ff <= 1'b0;
            if (frameStart) begin
               serialOutPos_ff <= 1'b1;
               serialOutNeg_ff <= 1'b0;
            end else if (txBit_ff == 4'ha) begin
               serialOutPos_ff <= 1'b0;
               serialOutNeg_ff <= 1'b1;
            end else begin
               serialOutPos_ff <= txData_ff[txBit_ff];
               serialOutNeg_ff <= ~txData_ff[txBit_ff];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Deserializer
   // ---------------------------------------------------------------
   reg [11:0] rxShift_ff;
   reg [3:0] rxBit_ff;
   reg [2:0] goodCnt_ff;
   reg [2:0] badCnt_ff;
   reg [5:0] lockTimer_ff;
   reg [5:0] lockLimit_ff;
   wire [11:0] nxt_rxShift = {rxBit, rxShift_ff[11:1]};
   wire frameOk = nxt_rxShift[0] & ~nxt_rxShift[11];
   wire boundary = refRise & (rxBit_ff == `SLLC_LAST_BIT);

   // Lock search, loss detect and word output on sampled ref edges
   always @(posedge clock) begin
      if (rst | ~awake) begin
         rxShift_ff <= 12'h000;
         rxBit_ff <= 4'h0;
         goodCnt_ff <= 3'h0;
         badCnt_ff <= 3'h0;
         lockN_ff <= 1'b1;
         parallelOeN_ff <= 1'b1;
         parallelWordOut_ff <= 10'h000;
         wordStrobe_ff <= 1'b0;
      end else begin
         wordStrobe_ff <= 1'b0;
         if (refRise) begin
            rxShift_ff <= nxt_rxShift;
            rxBit_ff <= rxBit_ff + 4'h1;
         end
         if (boundary) begin
            rxBit_ff <= 4'h0;
            if (~lockN_ff) begin
               // Corrupt words still go out until loss is declared
               parallelWordOut_ff <= nxt_rxShift[10:1];
               wordStrobe_ff <= 1'b1;
               if (frameOk) begin
                  badCnt_ff <= 3'h0;
               end else if (badCnt_ff == `SLLC_LOSS_COUNT - 3'h1) begin
                  lockN_ff <= 1'b1;
                  parallelOeN_ff <= 1'b1;
                  badCnt_ff <= 3'h0;
                  goodCnt_ff <= 3'h0;
               end else begin
                  badCnt_ff <= badCnt_ff + 3'h1;
               end
            end else if (frameOk) begin
               if (goodCnt_ff == `SLLC_GOOD_COUNT - 3'h1) begin
                  lockN_ff <= 1'b0;
                  parallelOeN_ff <= 1'b0;
               end else begin
                  goodCnt_ff <= goodCnt_ff + 3'h1;
               end
            end else begin
               // Slip one bit and restart the search
               goodCnt_ff <= 3'h0;
               rxBit_ff <= `SLLC_LAST_BIT;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Lock time watchdog
   // ---------------------------------------------------------------
   // Flags a search that overruns its bound; it cannot shorten it, a
   // slow link clock makes the bound unreachable by construction
   always @(posedge clock) begin
      if (rst | ~awake) begin
         lockTimer_ff <= 6'h00;
         lockLimit_ff <= `SLLC_LOCK_PWRUP_LIM;
         lockLate_ff <= 1'b0;
      end else if (~lockN_ff) begin
         lockTimer_ff <= 6'h00;
         lockLimit_ff <= `SLLC_LOCK_PAT_LIM;
         lockLate_ff <= 1'b0;
      end else begin
         if (~sleepPrev_ff)
            lockLimit_ff <= `SLLC_LOCK_PWRUP_LIM;
         if (lockTimer_ff != 6'h3f)
            lockTimer_ff <= lockTimer_ff + 6'h01;
         if (lockTimer_ff >= lockLimit_ff)
            lockLate_ff <= 1'b1;
      end
   end

endmodule // sllc_link_lock

`default_nettype wire

// ### tb/sllc_far_ser.sv
/* Far-side serializer model driving frames and the reference clock.
   Assumes the bench sets en, train and word; train and word taken at frame start, en per bit. */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Frame sender
// ------------------------------------------------------------
module sllc_far_ser (
   input wire logic en,
   input wire logic train,
   input wire logic [9:0] word,
   output logic reference_clock_in,
   output logic pos,
   output logic neg
);
   logic [11:0] frame;
   int k;
   // Clock runs free; data moves on its fall, sampled on its rise
   initial begin
      reference_clock_in = 1'h0;
      pos = 1'h0;
      neg = 1'h1;
      forever begin
         // Training word while train is high, the fed-back lock flag when farFeed is set
         frame = {1'h0, train ? 10'h001 : word, 1'h1};
         for (k = 0; k < 12; k++) begin
            if (en) begin
               pos = frame[k]; // Patterns already sent before wake
               neg = ~frame[k];
            end else begin
               pos = 1'h1; // Released: failsafe bias pulls pos up
               neg = 1'h0;
            end
            #400 reference_clock_in = 1'h1;
            #400 reference_clock_in = 1'h0;
         end
      end
   end
endmodule // sllc_far_ser
`default_nettype wire

// ### tb/sllc_link_lock_checker.sv
/* Port-level checker for the link lock block.
   Assumes one clock domain with synchronous reset rst. */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module sllc_link_lock_checker (
   input wire logic clock,
   input wire logic rst,
   input wire logic sleepRequestN,
   input wire logic serialOutPos_ff,
   input wire logic serialOutNeg_ff,
   input wire logic serialOeN_ff,
   input wire logic lockN_ff,
   input wire logic parallelOeN_ff,
   input wire logic wordStrobe_ff
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_reset_idle: assert property (
      $fell(rst) |-> lockN_ff && parallelOeN_ff && serialOeN_ff)
      else $error("outputs not idle after reset");
   a_oe_tracks_lock: assert property (parallelOeN_ff == lockN_ff)
      else $error("word enable differs from lock");
   a_neg_inverse: assert property (
      !serialOeN_ff |-> serialOutNeg_ff != serialOutPos_ff)
      else $error("serial pair not inverse");
   a_asleep_quiet: assert property (
      serialOeN_ff |-> !serialOutPos_ff && !serialOutNeg_ff)
      else $error("serial outs active while undriven");
   a_bit_stands: assert property (
      !serialOeN_ff && $changed(serialOutPos_ff)
      |=> ($stable(serialOutPos_ff) || serialOeN_ff) [*7])
      else $error("serial bit shorter than 8 clocks");
   a_strobe_locked: assert property (
      wordStrobe_ff |-> !$past(lockN_ff))
      else $error("word strobe while unlocked");
   a_strobe_pulse: assert property (
      wordStrobe_ff |=> !wordStrobe_ff [*8])
      else $error("word strobes too close");
   a_sleep_unlocks: assert property (
      !sleepRequestN [*4] |-> lockN_ff && serialOeN_ff)
      else $error("sleep did not stop link");
   // Main scenarios reached
   c_lock: cover property ($fell(lockN_ff));
   c_loss: cover property ($rose(lockN_ff));
   c_word: cover property (wordStrobe_ff);
endmodule // sllc_link_lock_checker
bind sllc_link_lock sllc_link_lock_checker i_chk (.clock(clock), .rst(rst),
   .sleepRequestN(sleepRequestN), .serialOutPos_ff(serialOutPos_ff),
   .serialOutNeg_ff(serialOutNeg_ff), .serialOeN_ff(serialOeN_ff),
   .lockN_ff(lockN_ff), .parallelOeN_ff(parallelOeN_ff),
   .wordStrobe_ff(wordStrobe_ff));
`default_nettype wire

// ### tb/sllc_link_lock_tb_top.sv
/* Self-checking bench for the link lock block with a far-side model.
   Assumes a 100 ns clock and an 800 ns serial bit time. */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module sllc_link_lock_tb_top;
   logic clock, rst, txValid, txReady, patternRequestA, patternRequestB;
   logic sleepRequestN, serialOutPos_ff, serialOutNeg_ff, serialOeN_ff;
   logic referenceClockIn, serialInPos, serialInNeg, lockN_ff, farEn;
   logic parallelOeN_ff, wordStrobe_ff, lockLate_ff, farFeed;
   logic [9:0] txWord, parallelWordOut_ff, farWord;
   logic [11:0] got [4];
   int error_cnt, comparisons;
   sllc_link_lock i_dut (.clock, .rst, .txWord, .txValid, .txReady,
      .patternRequestA, .patternRequestB, .sleepRequestN, .serialOutPos_ff,
      .serialOutNeg_ff, .serialOeN_ff, .referenceClockIn, .serialInPos,
      .serialInNeg, .lockN_ff, .parallelWordOut_ff, .parallelOeN_ff,
      .wordStrobe_ff, .lockLate_ff);
   sllc_far_ser i_far (.en(farEn), .train(farFeed & lockN_ff),
      .word(farWord), .reference_clock_in(referenceClockIn), .pos(serialInPos),
      .neg(serialInNeg));
   // System clock
   initial begin
      clock = 1'h0;
      forever #50 clock = ~clock;
   end
   task chk(input logic [11:0] seen, input logic [11:0] exp, input string nm);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task end_sim;
      $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Bounded wait on lock (sel 0) or strobe (sel 1); running out ends run
   task await(input logic sel, input logic v, input int n);
      int i;
      for (i = 0; i < n && (sel ? wordStrobe_ff : lockN_ff) !== v; i++)
         @(negedge clock);
      if ((sel ? wordStrobe_ff : lockN_ff) !== v) begin
         error_cnt++;
         end_sim();
      end
   endtask
   // Only frame starts rise in the words used here
   task wait_start;
      int i;
      logic p;
      @(negedge clock);
      p = serialOutPos_ff;
      for (i = 0; i < 400; i++) begin
         @(negedge clock);
         if (!p && serialOutPos_ff) return;
         p = serialOutPos_ff;
      end
      error_cnt++;
      end_sim();
   endtask
   // Sample mid-bit, 8 clocks a bit, 12 bits a frame
   task grab(input int n);
      int t;
      for (t = 0; t < 96 * n; t++) begin
         if (t % 8 == 4) got[t / 96][(t % 96) / 8] = serialOutPos_ff;
         @(negedge clock);
      end
   endtask
   task do_reset;
      @(posedge clock) rst <= 1'h1;
      repeat (4) @(posedge clock);
      rst <= 1'h0;
   endtask
   task t_reset;
      do_reset();
      @(negedge clock);
      chk(lockN_ff, 1'h1, "lockN");
      chk(parallelOeN_ff, 1'h1, "parallelOeN");
   endtask
   // With fb set the far side trains until lock, then sends w
   task t_lock(input logic [9:0] w, input logic fb);
      @(posedge clock);
      farWord <= w;
      farEn <= 1'h1;
      farFeed <= fb;
      await(1'h0, 1'h0, 3000);
      chk(parallelOeN_ff, 1'h0, "parallelOeN");
      chk(lockLate_ff, 1'h1, "lockLate");
      await(1'h1, 1'h1, 200);
      chk(lockLate_ff, 1'h0, "lockLate");
      chk(parallelWordOut_ff, w, "parallelWordOut");
   endtask
   // Far side released: loss only after four bad boundaries
   task t_loss;
      @(posedge clock) farEn <= 1'h0;
      repeat (280) @(negedge clock);
      chk(lockN_ff, 1'h0, "lockN");
      repeat (140) @(negedge clock);
      chk(lockN_ff, 1'h1, "lockN");
   endtask
   task t_sleep;
      @(posedge clock) sleepRequestN <= 1'h0;
      repeat (6) @(negedge clock);
      chk(serialOeN_ff, 1'h1, "serialOeN");
      chk(lockN_ff, 1'h1, "lockN");
      @(posedge clock) sleepRequestN <= 1'h1;
   endtask
   // Fill the FIFO in one idle frame, then read four frames back
   task t_send;
      int i;
      logic [9:0] w [4];
      w = '{10'h003, 10'h00F, 10'h07F, 10'h1FF};
      wait_start();
      for (i = 0; i < 4; i++) begin
         @(posedge clock);
         txWord <= w[i];
         txValid <= 1'h1;
      end
      @(posedge clock) txValid <= 1'h0;
      repeat (2) @(negedge clock);
      chk(txReady, 1'h0, "txReady");
      wait_start();
      grab(4);
      for (i = 0; i < 4; i++) chk(got[i], {1'h0, w[i], 1'h1}, "frame");
   endtask
   // Short request on either input still gives training frames later
   task t_request;
      int r;
      for (r = 0; r < 2; r++) begin
         do_reset();
         patternRequestA <= (r == 0);
         patternRequestB <= (r == 1);
         repeat (20) @(posedge clock);
         patternRequestA <= 1'h0;
         patternRequestB <= 1'h0;
         wait_start();
         wait_start();
         grab(1);
         chk(got[0], {1'h0, 10'h001, 1'h1}, "training");
      end
   endtask
   // Main sequence
   initial begin
      rst = 1'h1;
      txWord = 10'h000;
      txValid = 1'h0;
      patternRequestA = 1'h0;
      patternRequestB = 1'h0;
      sleepRequestN = 1'h1;
      farEn = 1'h1;
      farFeed = 1'h0;
      farWord = 10'h001;
      error_cnt = 0;
      comparisons = 0;
      t_reset();
      t_lock(10'h003, 1'h1);
      t_loss();
      t_lock(10'h0FF, 1'h0);
      t_sleep();
      t_send();
      t_request();
      end_sim();
   end
endmodule // sllc_link_lock_tb_top
`default_nettype wire
